// ==== core/wtmr_consts.vh ====
// Constants for the wrap timer: register offsets, field positions, reset values
`ifndef WTMR_CONSTS_VH
`define WTMR_CONSTS_VH
// Register byte addresses (word aligned)
`define WTMR_ADDR_STATUS_CONTROL 5'h00
`define WTMR_ADDR_CLOCK_CONFIG 5'h04
`define WTMR_ADDR_CURRENT_COUNT 5'h08
`define WTMR_ADDR_WRAP_LIMIT 5'h0C
`define WTMR_ADDR_IRQ_STATUS 5'h10
`define WTMR_ADDR_IRQ_ENABLE 5'h14
`define WTMR_ADDR_IRQ_CLEAR 5'h18
`define WTMR_ADDR_W 5
// Status/control fields
`define WTMR_SC_OVF 7
`define WTMR_SC_IRQ_EN 6
`define WTMR_SC_CNT_RST 5
`define WTMR_SC_HALT 4
// Clock config fields
`define WTMR_CLK_SRC_HI 5
`define WTMR_CLK_SRC_LO 4
`define WTMR_CLK_DIV_HI 3
`define WTMR_CLK_DIV_LO 0
// Source select codes
`define WTMR_SRC_BUS 2'h0
`define WTMR_SRC_FIXED 2'h1
`define WTMR_SRC_EXT_FALL 2'h2
`define WTMR_SRC_EXT_RISE 2'h3
// Highest divider code; higher codes divide by 256
`define WTMR_DIV_MAX 4'h8
// Reset values
`define WTMR_RST_COUNT 8'h00
`define WTMR_RST_WRAP 8'h00
`define WTMR_RST_CLKCFG 6'h00
`define WTMR_RST_HALT 1'b1
`define WTMR_ZERO8 8'h00
`define WTMR_ONE8 8'h01
`define WTMR_ZERO32 32'h00000000
`endif

// ==== core/wtmr_top.v ====
// Wrap timer: 8-bit modulo up-counter with Avalon-MM register slave
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "wtmr_consts.vh"

// How it works
// - Overflow flag sets when count wraps from wrap limit to zero.
// - Flag clears by reading status/control while set, then writing 0 to it.
// - Counter-reset write of 1 or any wrap-limit write also clears the flag.
// - Bit 6 enables o_overflow_irq; request while enable and flag; reset clears enable.
// - Writing 1 to bit 5 zeroes count and clears flag; reads as 0.
// - Halt bit 4 holds count; clearing resumes; reset sets halt.
// - Unused bits read zero: status 3:0, clock config 7:6.
// - Source select 5:4: bus, fixed clock, pin falling, pin rising.
// - Changing source leaves count untouched; counting continues.
// - Reset clears source and divider fields: bus clock divided by one.
// - Divider 3:0 divides by two to the code; codes above 8 divide by 256.
// - Changing divider leaves count untouched; counting continues.
// - Four 8-bit registers: status/control, clock config, count, wrap limit.
// - Wrap limit zero is free-running 255 to zero; reset clears it.
// - Count register is read-only; reset clears it.
// - Overflow between read and zero write cancels the clear.
module wtmr_top (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // Avalon-MM slave
   input wire [`WTMR_ADDR_W-1:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire [31:0] i_writedata,
   input wire [3:0] i_byteenable,
   output wire o_waitrequest,
   output reg [31:0] o_readdata,
   // Count sources
   input wire i_fixed_rate_clock,
   input wire i_external_count_input,
   // Interrupts
   output wire o_irq,
   output wire o_overflow_irq
);

   reg [7:0] count_reg;
   reg [7:0] wrap_reg;
   reg [5:0] clkcfg_reg;
   reg halt_reg;
   reg irq_en_reg;
   reg ovf_reg;
   reg ovf_armed_reg;
   reg [7:0] pre_reg;
   reg [2:0] ext_sync_reg;
   reg fix_sync1_reg;
   reg fix_sync2_reg;
   reg fix_prev_reg;
   reg ack_reg;
   reg evt_sts_reg;
   reg evt_en_reg;

   wire [1:0] src_sel = clkcfg_reg[`WTMR_CLK_SRC_HI:`WTMR_CLK_SRC_LO];
   wire [3:0] div_sel = clkcfg_reg[`WTMR_CLK_DIV_HI:`WTMR_CLK_DIV_LO];
   wire access_req = (i_read | i_write) & ~ack_reg;
   // Writes land at the completing edge, where the master sees waitrequest low
   wire wr = i_write & ack_reg & i_byteenable[0];
   wire rd = i_read & ~ack_reg;

   // One wait state: each access ends at the edge after it is seen
   assign o_waitrequest = (i_read | i_write) & ~ack_reg;

   function addr_hit;
      input [`WTMR_ADDR_W-1:0] a;
      input [`WTMR_ADDR_W-1:0] b;
      begin
         addr_hit = (a == b);
      end
   endfunction

   wire wr_sc = wr & addr_hit(i_address, `WTMR_ADDR_STATUS_CONTROL);
   wire wr_clk = wr & addr_hit(i_address, `WTMR_ADDR_CLOCK_CONFIG);
   wire wr_wrap = wr & addr_hit(i_address, `WTMR_ADDR_WRAP_LIMIT);
   wire wr_ien = wr & addr_hit(i_address, `WTMR_ADDR_IRQ_ENABLE);
   wire wr_iclr = wr & addr_hit(i_address, `WTMR_ADDR_IRQ_CLEAR);
   wire rd_sc = rd & addr_hit(i_address, `WTMR_ADDR_STATUS_CONTROL);
   wire cnt_rst = (wr_sc & i_writedata[`WTMR_SC_CNT_RST]) | wr_wrap;

   // Pin sampled by a two-stage synchroniser; third stage for edge detect
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_sync_reg <= 3'h0;
         fix_sync1_reg <= 1'b0;
         fix_sync2_reg <= 1'b0;
         fix_prev_reg <= 1'b0;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], i_external_count_input};
         fix_sync1_reg <= i_fixed_rate_clock;
         fix_sync2_reg <= fix_sync1_reg;
         fix_prev_reg <= fix_sync2_reg;
      end
   end

   wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
   wire ext_fall = ~ext_sync_reg[1] & ext_sync_reg[2];
   wire fix_rise = fix_sync2_reg & ~fix_prev_reg;

   // Source choice never touches the count
   reg src_tick;
   always @* begin
      case (src_sel)
         `WTMR_SRC_BUS: src_tick = 1'b1;
         `WTMR_SRC_FIXED: src_tick = fix_rise;
         `WTMR_SRC_EXT_FALL: src_tick = ext_fall;
         default: src_tick = ext_rise;
      endcase
   end

   // Prescaler: tick when the low div bits of the free counter are all ones
   reg [7:0] div_mask;
   always @* begin
      if (div_sel >= `WTMR_DIV_MAX) begin
         div_mask = 8'hFF;
      end else begin
         div_mask = (`WTMR_ONE8 << div_sel) - `WTMR_ONE8;
      end
   end

   wire running = ~halt_reg;
   wire pre_tick = running & src_tick & ((pre_reg & div_mask) == div_mask);
   wire at_wrap = (wrap_reg == `WTMR_ZERO8) ? (count_reg == 8'hFF) : (count_reg == wrap_reg);
   wire overflow = pre_tick & at_wrap & ~cnt_rst;

   // Prescaler counter and main count
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_reg <= `WTMR_ZERO8;
         count_reg <= `WTMR_RST_COUNT;
      end else begin
         if (cnt_rst) begin
            pre_reg <= `WTMR_ZERO8;
            count_reg <= `WTMR_ZERO8;
         end else if (running & src_tick) begin
            pre_reg <= pre_reg + `WTMR_ONE8;
            if (pre_tick) begin
               count_reg <= at_wrap ? `WTMR_ZERO8 : count_reg + `WTMR_ONE8;
            end
         end
      end
   end

   // Overflow flag and its two-step clear
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ovf_reg <= 1'b0;
         ovf_armed_reg <= 1'b0;
      end else begin
         if (overflow) begin
            ovf_reg <= 1'b1;
            ovf_armed_reg <= 1'b0;
         end else if (cnt_rst) begin
            ovf_reg <= 1'b0;
            ovf_armed_reg <= 1'b0;
         end else if (wr_sc & ~i_writedata[`WTMR_SC_OVF] & ovf_armed_reg) begin
            ovf_reg <= 1'b0;
            ovf_armed_reg <= 1'b0;
         end else if (rd_sc & ovf_reg) begin
            ovf_armed_reg <= 1'b1;
         end
      end
   end

   // Control registers
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         halt_reg <= `WTMR_RST_HALT;
         irq_en_reg <= 1'b0;
         clkcfg_reg <= `WTMR_RST_CLKCFG;
         wrap_reg <= `WTMR_RST_WRAP;
         evt_en_reg <= 1'b0;
      end else begin
         if (wr_sc) begin
            halt_reg <= i_writedata[`WTMR_SC_HALT];
            irq_en_reg <= i_writedata[`WTMR_SC_IRQ_EN];
         end
         if (wr_clk) begin
            clkcfg_reg <= i_writedata[5:0];
         end
         if (wr_wrap) begin
            wrap_reg <= i_writedata[7:0];
         end
         if (wr_ien) begin
            evt_en_reg <= i_writedata[0];
         end
      end
   end

   // Sticky overflow event for the system interrupt; set beats clear
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         evt_sts_reg <= 1'b0;
      end else if (overflow) begin
         evt_sts_reg <= 1'b1;
      end else if (wr_iclr & i_writedata[0]) begin
         evt_sts_reg <= 1'b0;
      end
   end

   assign o_overflow_irq = irq_en_reg & ovf_reg;
   assign o_irq = evt_en_reg & evt_sts_reg;

   // Read data, registered with the acknowledge
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_reg <= 1'b0;
         o_readdata <= `WTMR_ZERO32;
      end else begin
         ack_reg <= access_req;
         if (rd) begin
            if (addr_hit(i_address, `WTMR_ADDR_STATUS_CONTROL)) begin
               o_readdata <= {24'h000000, ovf_reg, irq_en_reg, 1'b0, halt_reg, 4'h0};
            end else if (addr_hit(i_address, `WTMR_ADDR_CLOCK_CONFIG)) begin
               o_readdata <= {24'h000000, 2'h0, clkcfg_reg};
            end else if (addr_hit(i_address, `WTMR_ADDR_CURRENT_COUNT)) begin
               o_readdata <= {24'h000000, count_reg};
            end else if (addr_hit(i_address, `WTMR_ADDR_WRAP_LIMIT)) begin
               o_readdata <= {24'h000000, wrap_reg};
            end else if (addr_hit(i_address, `WTMR_ADDR_IRQ_STATUS)) begin
               o_readdata <= {31'h00000000, evt_sts_reg};
            end else if (addr_hit(i_address, `WTMR_ADDR_IRQ_ENABLE)) begin
               o_readdata <= {31'h00000000, evt_en_reg};
            end else begin
               o_readdata <= `WTMR_ZERO32;
            end
         end
      end
   end

endmodule

// ==== tb/wtmr_props.sv ====
// Port checker for the wrap timer
`timescale 1ns/1ps
module wtmr_props (
   // Clock, reset and bus
   input wire i_clk,
   input wire i_rst_n,
   input wire [4:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire o_waitrequest,
   input wire [31:0] o_readdata,
   // Interrupts
   input wire o_irq,
   input wire o_overflow_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire rdone = i_read && !o_waitrequest;
   wait_one_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("wait state too long");
   high_zero_a: assert property (rdone |-> o_readdata[31:8] == 24'h0)
      else $error("upper read bits set");
   sc_unused_a: assert property (rdone && i_address == 5'h00 |-> o_readdata[5] == 1'b0 && o_readdata[3:0] == 4'h0)
      else $error("status unused bits set");
   clk_unused_a: assert property (rdone && i_address == 5'h04 |-> o_readdata[7:6] == 2'h0)
      else $error("clock config unused bits set");
   unmapped_a: assert property (rdone && i_address > 5'h18 |-> o_readdata == 32'h0)
      else $error("unmapped read not zero");
   data_hold_a: assert property (!i_read |=> $stable(o_readdata))
      else $error("read data moved");
   irq_reset_a: assert property ($rose(i_rst_n) |-> !o_overflow_irq && !o_irq)
      else $error("interrupt up after reset");
   ovf_fall_a: assert property ($fell(o_overflow_irq) && $past(i_rst_n) |-> $past(i_write))
      else $error("overflow irq fell without write");
   irq_fall_a: assert property ($fell(o_irq) && $past(i_rst_n) |-> $past(i_write))
      else $error("irq fell without write");
   c_rd: cover property (rdone && i_address == 5'h00);
   c_ovf: cover property ($rose(o_overflow_irq));
   c_irq: cover property ($rose(o_irq));
endmodule
bind wtmr_top wtmr_props u_props (.i_clk, .i_rst_n, .i_address, .i_read, .i_write, .o_waitrequest, .o_readdata,
   .o_irq, .o_overflow_irq);

// ==== tb/test_modulo_timer_8bit.sv ====
// Self-checking bench for the wrap timer
`timescale 1ns/1ps
module test_modulo_timer_8bit;
   reg i_clk = 0, i_rst_n = 0, i_read = 0, i_write = 0, fx = 0, px = 0;
   reg [4:0] i_address = 0;
   reg [31:0] i_writedata = 0, rd;
   wire o_waitrequest, o_irq, o_overflow_irq;
   wire [31:0] o_readdata;
   integer miscompares = 0, total_checks = 0, cyc = 0, i, s, d, q, c, e;
   wtmr_top u_dut (.i_clk, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable(4'hF),
      .o_waitrequest, .o_readdata, .i_fixed_rate_clock(fx), .i_external_count_input(px), .o_irq, .o_overflow_irq);
   initial forever #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      fx <= (cyc % 8) < 4;
      px <= (cyc % 12) < 6;
      if (cyc == 90000) begin
         miscompares = miscompares + 1;
         report_and_stop;
      end
   end
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] x);
      begin
         total_checks = total_checks + 1;
         if (g !== x) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
         end
      end
   endtask
   // One bus transfer; read data taken where waitrequest is low
   task xfer(input w, input [4:0] a, input [7:0] v);
      begin
         @(posedge i_clk);
         i_read <= !w;
         i_write <= w;
         i_address <= a;
         i_writedata <= {24'h0, v};
         @(posedge i_clk);
         while (o_waitrequest !== 1'b0) @(posedge i_clk);
         rd = o_readdata;
         i_read <= 0;
         i_write <= 0;
      end
   endtask
   task rdc(input [4:0] a, input [31:0] x);
      begin
         xfer(0, a, 8'h00);
         chk(rd, x);
      end
   endtask
   // Count within one of the expected value
   task near(input integer x);
      begin
         xfer(0, 5'h08, 8'h00);
         chk({31'h0, rd + 32'h1 - x <= 32'h2}, 32'h1);
      end
   endtask
   // Run free from zero, rewrite config mid-run, then halt
   task run(input [7:0] cfg, input integer n);
      begin
         xfer(1, 5'h0C, 8'h00);
         xfer(1, 5'h04, cfg);
         xfer(1, 5'h00, 8'h00);
         repeat (n) @(posedge i_clk);
         xfer(1, 5'h04, cfg);
         repeat (n) @(posedge i_clk);
         xfer(1, 5'h00, 8'h10);
      end
   endtask
   initial begin
      i = $urandom(33483);
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1;
      rdc(5'h00, 32'h10);
      rdc(5'h04, 32'h0);
      rdc(5'h0C, 32'h0);
      rdc(5'h1C, 32'h0);
      xfer(1, 5'h08, 8'hA5);
      rdc(5'h08, 32'h0);
      for (i = 0; i < 8; i = i + 1) begin
         s = i % 4;
         d = s ? $urandom % 3 : $urandom % 10;
         q = d > 8 ? 8 : d;
         e = (s == 0) ? 1 : (s == 1) ? 8 : 12;
         c = ((8 + $urandom % 16) << q) * e / 2;
         run({2'b00, s[1:0], d[3:0]}, c);
         near(((2 * c + 6) / e) >> q);
      end
      repeat (40) @(posedge i_clk);
      near(((2 * c + 6) / e) >> q);
      run(8'h00, 150);
      rdc(5'h00, 32'h90);
      xfer(1, 5'h00, 8'h10);
      rdc(5'h00, 32'h10);
      run(8'h00, 150);
      xfer(1, 5'h00, 8'h10);
      rdc(5'h00, 32'h90);
      xfer(1, 5'h0C, 8'h07);
      rdc(5'h00, 32'h10);
      xfer(1, 5'h00, 8'h00);
      repeat (20) @(posedge i_clk);
      rdc(5'h00, 32'h80);
      repeat (10) @(posedge i_clk);
      xfer(1, 5'h00, 8'h10);
      rdc(5'h00, 32'h90);
      xfer(1, 5'h00, 8'h30);
      rdc(5'h00, 32'h10);
      rdc(5'h08, 32'h0);
      xfer(1, 5'h00, 8'h40);
      repeat (20) @(posedge i_clk);
      xfer(1, 5'h00, 8'h50);
      @(negedge i_clk);
      chk({31'h0, o_overflow_irq}, 32'h1);
      rdc(5'h00, 32'hD0);
      xfer(1, 5'h14, 8'h01);
      @(negedge i_clk);
      chk({31'h0, o_irq}, 32'h1);
      xfer(1, 5'h18, 8'h01);
      @(negedge i_clk);
      chk({31'h0, o_irq}, 32'h0);
      i_rst_n <= 0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1;
      chk({31'h0, o_overflow_irq}, 32'h0);
      rdc(5'h00, 32'h10);
      report_and_stop;
   end
endmodule
